// ---- src/crf_pkg.sv ----
// package of constants for the cpu register file
`default_nettype none
package crf_pkg;
    localparam int REG_W = 8;
    localparam int WORD_W = 16;
    // 8-bit register select codes, one per bank register
    localparam logic [2:0] SEL_ACC = 3'h0;
    localparam logic [2:0] SEL_FLAG = 3'h1;
    localparam logic [2:0] SEL_P0H = 3'h2;
    localparam logic [2:0] SEL_P0L = 3'h3;
    localparam logic [2:0] SEL_P1H = 3'h4;
    localparam logic [2:0] SEL_P1L = 3'h5;
    localparam logic [2:0] SEL_P2H = 3'h6;
    localparam logic [2:0] SEL_P2L = 3'h7;
    localparam int BANK_REGS = 8;
    // 16-bit pair select codes
    localparam logic [1:0] PAIR_0 = 2'h0;
    localparam logic [1:0] PAIR_1 = 2'h1;
    localparam logic [1:0] PAIR_2 = 2'h2;
    // special register select codes
    localparam logic [2:0] SPC_VBASE = 3'h0;
    localparam logic [2:0] SPC_REFRESH = 3'h1;
    localparam logic [2:0] SPC_IDX1 = 3'h2;
    localparam logic [2:0] SPC_IDX2 = 3'h3;
    localparam logic [2:0] SPC_STACK = 3'h4;
    localparam logic [2:0] SPC_FETCH = 3'h5;
    // interrupt-enable flip-flop commands
    localparam logic [2:0] IEN_NONE = 3'h0;
    localparam logic [2:0] IEN_OFF = 3'h1;
    localparam logic [2:0] IEN_ON = 3'h2;
    localparam logic [2:0] IEN_NMI_ACCEPT = 3'h3;
    localparam logic [2:0] IEN_NMI_RETURN = 3'h4;
    // reset values and the refresh step
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [6:0] REFRESH_STEP = 7'h01;
endpackage
`default_nettype wire

// ---- src/crf_bank.sv ----
// one bank of eight 8-bit registers with byte and pair write ports
`default_nettype none
module crf_bank
    import crf_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic byte_we_i,
    input wire logic [2:0] byte_sel_i,
    input wire logic [7:0] byte_wdata_i,
    input wire logic pair_we_i,
    input wire logic [1:0] pair_sel_i,
    input wire logic [15:0] pair_wdata_i,
    output logic [63:0] regs_o
);
    typedef struct packed {
        logic [BANK_REGS-1:0][7:0] regs;
    } crf_bank_state_t;

    crf_bank_state_t st_r;
    crf_bank_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        // pair write is atomic: both halves land on the same edge
        if (pair_we_i && pair_sel_i != 2'h3) begin
            st_nxt.regs[{pair_sel_i, 1'b0} + 3'h2] = pair_wdata_i[15:8];
            st_nxt.regs[{pair_sel_i, 1'b0} + 3'h3] = pair_wdata_i[7:0];
        end else if (byte_we_i) begin
            st_nxt.regs[byte_sel_i] = byte_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regs_o = st_r.regs;

    chk_pair_atomic: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (pair_we_i && pair_sel_i == PAIR_1) |=>
        (st_r.regs[SEL_P1H] == $past(pair_wdata_i[15:8])
        && st_r.regs[SEL_P1L] == $past(pair_wdata_i[7:0])))
        else $error("pair write not atomic");
endmodule
`default_nettype wire

// ---- src/crf_top.sv ----
// programmer-visible register file of an 8-bit processor
`default_nettype none
module crf_top
    import crf_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // bank register byte access
    input wire logic [2:0] byte_rsel_i,
    output logic [7:0] byte_rdata_o,
    input wire logic byte_we_i,
    input wire logic [2:0] byte_wsel_i,
    input wire logic [7:0] byte_wdata_i,
    // bank register pair access
    input wire logic [1:0] pair_rsel_i,
    output logic [15:0] pair_rdata_o,
    input wire logic pair_we_i,
    input wire logic [1:0] pair_wsel_i,
    input wire logic [15:0] pair_wdata_i,
    // datapath accumulator and flags
    output logic [7:0] accumulator_o,
    output logic [7:0] flags_o,
    input wire logic acc_we_i,
    input wire logic [7:0] acc_result_i,
    input wire logic flag_we_i,
    input wire logic [7:0] flag_result_i,
    // bank exchange
    input wire logic exchange_i,
    output logic bank_sel_o,
    // special registers
    input wire logic [2:0] spc_rsel_i,
    output logic [15:0] spc_rdata_o,
    input wire logic spc_we_i,
    input wire logic [2:0] spc_wsel_i,
    input wire logic [15:0] spc_wdata_i,
    output logic [7:0] vector_base_o,
    output logic [15:0] index_first_o,
    output logic [15:0] index_second_o,
    output logic [15:0] stack_top_pointer_o,
    output logic [15:0] fetch_address_o,
    // instruction fetch and refresh
    input wire logic fetch_i,
    output logic [7:0] refresh_addr_o,
    // interrupt status
    input wire logic [2:0] ien_cmd_i,
    input wire logic mode_we_i,
    input wire logic [1:0] mode_wdata_i,
    output logic enable_flop_primary_o,
    output logic enable_flop_saved_o,
    output logic mode_flop_low_o,
    output logic mode_flop_high_o,
    input wire logic [7:0] periph_vector_i,
    output logic [15:0] table_pointer_o
);
    typedef struct packed {
        logic bank_sel;
        logic [7:0] vector_base;
        logic [7:0] refresh_counter;
        logic [15:0] index_first;
        logic [15:0] index_second;
        logic [15:0] stack_top_pointer;
        logic [15:0] fetch_address;
        logic enable_flop_primary;
        logic enable_flop_saved;
        logic mode_flop_low;
        logic mode_flop_high;
        logic [7:0] byte_rdata;
        logic [15:0] pair_rdata;
        logic [15:0] spc_rdata;
    } crf_state_t;

    crf_state_t st_r;
    crf_state_t st_nxt;

    logic [1:0][63:0] bank_regs;
    logic [1:0] bank_byte_we;
    logic [1:0] bank_pair_we;
    logic [2:0] bank_byte_sel;
    logic [7:0] bank_byte_wdata;
    logic [BANK_REGS-1:0][7:0] vis;

    // two banks of eight registers each
    // the visible bank is picked by one select bit; data never moves
    assign vis = bank_regs[st_r.bank_sel];

    // datapath results win over the generic byte port into the same cycle
    always_comb begin
        bank_byte_sel = byte_wsel_i;
        bank_byte_wdata = byte_wdata_i;
        if (acc_we_i) begin
            bank_byte_sel = SEL_ACC;
            bank_byte_wdata = acc_result_i;
        end else if (flag_we_i) begin
            bank_byte_sel = SEL_FLAG;
            bank_byte_wdata = flag_result_i;
        end
    end

    genvar gb;
    generate
        for (gb = 0; gb < 2; gb++) begin : g_bank
            assign bank_byte_we[gb] = (byte_we_i || acc_we_i || flag_we_i)
                                      && (st_r.bank_sel == 1'(gb));
            assign bank_pair_we[gb] = pair_we_i && (st_r.bank_sel == 1'(gb));
            crf_bank u_bank (
                .sys_clk_i(sys_clk_i),
                .rst_n_i(rst_n_i),
                .byte_we_i(bank_byte_we[gb]),
                .byte_sel_i(bank_byte_sel),
                .byte_wdata_i(bank_byte_wdata),
                .pair_we_i(bank_pair_we[gb]),
                .pair_sel_i(pair_wsel_i),
                .pair_wdata_i(pair_wdata_i),
                .regs_o(bank_regs[gb])
            );
        end
    endgenerate

    always_comb begin
        st_nxt = st_r;
        if (exchange_i) begin
            st_nxt.bank_sel = ~st_r.bank_sel;
        end
        // refresh counter keeps bit seven, steps the low seven
        if (fetch_i) begin
            st_nxt.refresh_counter = {st_r.refresh_counter[7],
                                      st_r.refresh_counter[6:0] + REFRESH_STEP};
        end
        if (spc_we_i) begin
            case (spc_wsel_i)
                SPC_VBASE: st_nxt.vector_base = spc_wdata_i[7:0];
                SPC_REFRESH: st_nxt.refresh_counter = spc_wdata_i[7:0];
                SPC_IDX1: st_nxt.index_first = spc_wdata_i;
                SPC_IDX2: st_nxt.index_second = spc_wdata_i;
                SPC_STACK: st_nxt.stack_top_pointer = spc_wdata_i;
                SPC_FETCH: st_nxt.fetch_address = spc_wdata_i;
                default: st_nxt.fetch_address = st_r.fetch_address;
            endcase
        end
        case (ien_cmd_i)
            IEN_OFF: begin
                st_nxt.enable_flop_primary = 1'b0;
                st_nxt.enable_flop_saved = 1'b0;
            end
            IEN_ON: begin
                st_nxt.enable_flop_primary = 1'b1;
                st_nxt.enable_flop_saved = 1'b1;
            end
            IEN_NMI_ACCEPT: begin
                st_nxt.enable_flop_saved = st_r.enable_flop_primary;
                st_nxt.enable_flop_primary = 1'b0;
            end
            IEN_NMI_RETURN: begin
                st_nxt.enable_flop_primary = st_r.enable_flop_saved;
            end
            default: st_nxt.enable_flop_primary = st_r.enable_flop_primary;
        endcase
        if (mode_we_i) begin
            st_nxt.mode_flop_low = mode_wdata_i[0];
            st_nxt.mode_flop_high = mode_wdata_i[1];
        end
        // registered reads, one cycle after the select
        // pair read: first register high byte, second low byte
        st_nxt.byte_rdata = vis[byte_rsel_i];
        case (pair_rsel_i)
            PAIR_0: st_nxt.pair_rdata = {vis[SEL_P0H], vis[SEL_P0L]};
            PAIR_1: st_nxt.pair_rdata = {vis[SEL_P1H], vis[SEL_P1L]};
            PAIR_2: st_nxt.pair_rdata = {vis[SEL_P2H], vis[SEL_P2L]};
            default: st_nxt.pair_rdata = RST_WORD;
        endcase
        case (spc_rsel_i)
            SPC_VBASE: st_nxt.spc_rdata = {RST_BYTE, st_r.vector_base};
            SPC_REFRESH: st_nxt.spc_rdata = {RST_BYTE, st_r.refresh_counter};
            SPC_IDX1: st_nxt.spc_rdata = st_r.index_first;
            SPC_IDX2: st_nxt.spc_rdata = st_r.index_second;
            SPC_STACK: st_nxt.spc_rdata = st_r.stack_top_pointer;
            SPC_FETCH: st_nxt.spc_rdata = st_r.fetch_address;
            default: st_nxt.spc_rdata = RST_WORD;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign byte_rdata_o = st_r.byte_rdata;
    assign pair_rdata_o = st_r.pair_rdata;
    assign spc_rdata_o = st_r.spc_rdata;
    // accumulator and flags always presented to the datapath
    assign accumulator_o = vis[SEL_ACC];
    assign flags_o = vis[SEL_FLAG];
    assign bank_sel_o = st_r.bank_sel;
    assign vector_base_o = st_r.vector_base;
    assign index_first_o = st_r.index_first;
    assign index_second_o = st_r.index_second;
    assign stack_top_pointer_o = st_r.stack_top_pointer;
    assign fetch_address_o = st_r.fetch_address;
    // all eight bits go out for the refresh address
    assign refresh_addr_o = st_r.refresh_counter;
    assign enable_flop_primary_o = st_r.enable_flop_primary;
    assign enable_flop_saved_o = st_r.enable_flop_saved;
    assign mode_flop_low_o = st_r.mode_flop_low;
    assign mode_flop_high_o = st_r.mode_flop_high;
    // table pointer: vector base high, peripheral byte low
    assign table_pointer_o = {st_r.vector_base, periph_vector_i};

    chk_bank_toggle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        exchange_i |=> bank_sel_o != $past(bank_sel_o))
        else $error("exchange did not toggle bank");
    // a write beside the first swap lands in the view that comes back, so it is excluded
    sequence s_exch_quiet;
        exchange_i && !byte_we_i && !pair_we_i && !acc_we_i && !flag_we_i;
    endsequence
    // double exchange restores the accumulator of the view
    chk_exch_keep: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (s_exch_quiet ##1 s_exch_quiet)
        |=> accumulator_o == $past(accumulator_o, 2))
        else $error("exchange lost data");
    chk_bank_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !exchange_i |=> $stable(bank_sel_o))
        else $error("bank moved without exchange");
    // refresh low bits step, bit seven held
    chk_refresh_step: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (fetch_i && !spc_we_i) |=> (refresh_addr_o[7] == $past(refresh_addr_o[7])
        && refresh_addr_o[6:0] == $past(refresh_addr_o[6:0]) + 7'h01))
        else $error("refresh step wrong");
    chk_ien_on: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ien_cmd_i == IEN_ON |=> enable_flop_primary_o && enable_flop_saved_o)
        else $error("enable on failed");
    chk_ien_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ien_cmd_i == IEN_OFF |=> !enable_flop_primary_o && !enable_flop_saved_o)
        else $error("enable off failed");
    // nmi accept saves primary then clears it
    chk_nmi_accept: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ien_cmd_i == IEN_NMI_ACCEPT |=> (!enable_flop_primary_o
        && enable_flop_saved_o == $past(enable_flop_primary_o)))
        else $error("nmi accept wrong");
    chk_nmi_return: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ien_cmd_i == IEN_NMI_RETURN |=> enable_flop_primary_o == $past(enable_flop_saved_o))
        else $error("nmi return wrong");
    chk_fetch_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (spc_we_i && spc_wsel_i == SPC_FETCH) |=> fetch_address_o == $past(spc_wdata_i))
        else $error("fetch address write lost");
    // mode flops follow a mode write
    chk_mode_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        mode_we_i |=> {mode_flop_high_o, mode_flop_low_o} == $past(mode_wdata_i))
        else $error("mode write lost");
    // pair read assembles high and low bytes
    chk_pair_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (pair_rsel_i == PAIR_2) |=> pair_rdata_o == {$past(vis[SEL_P2H]), $past(vis[SEL_P2L])})
        else $error("pair read order wrong");
    chk_pair0_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (pair_rsel_i == PAIR_0) |=> pair_rdata_o == {$past(vis[SEL_P0H]), $past(vis[SEL_P0L])})
        else $error("first pair read order wrong");
    chk_vbase_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (spc_we_i && spc_wsel_i == SPC_VBASE) |=> vector_base_o == $past(spc_wdata_i[7:0]))
        else $error("vector base write lost");
    chk_idx1_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (spc_we_i && spc_wsel_i == SPC_IDX1) |=> index_first_o == $past(spc_wdata_i))
        else $error("first index write lost");
    chk_idx2_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (spc_we_i && spc_wsel_i == SPC_IDX2) |=> index_second_o == $past(spc_wdata_i))
        else $error("second index write lost");
    chk_stack_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (spc_we_i && spc_wsel_i == SPC_STACK) |=> stack_top_pointer_o == $past(spc_wdata_i))
        else $error("stack pointer write lost");
    chk_stack_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (spc_rsel_i == SPC_STACK) |=> spc_rdata_o == $past(stack_top_pointer_o))
        else $error("stack pointer read wrong");
    // a refresh load beats the fetch step
    chk_refresh_load: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (spc_we_i && spc_wsel_i == SPC_REFRESH) |=> refresh_addr_o == $past(spc_wdata_i[7:0]))
        else $error("refresh load lost");
    chk_refresh_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (!(fetch_i || (spc_we_i && spc_wsel_i == SPC_REFRESH))) |=> $stable(refresh_addr_o))
        else $error("refresh moved without fetch");
    chk_ien_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (ien_cmd_i == IEN_NONE) |=> ($stable(enable_flop_primary_o) && $stable(enable_flop_saved_o)))
        else $error("enables moved without command");
    chk_mode_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !mode_we_i |=> ($stable(mode_flop_low_o) && $stable(mode_flop_high_o)))
        else $error("mode moved without write");
    chk_acc_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (acc_we_i && !pair_we_i && !exchange_i) |=> accumulator_o == $past(acc_result_i))
        else $error("accumulator write lost");
    chk_flag_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (flag_we_i && !acc_we_i && !pair_we_i && !exchange_i) |=> flags_o == $past(flag_result_i))
        else $error("flag write lost");
    chk_acc_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (byte_rsel_i == SEL_ACC) |=> byte_rdata_o == $past(accumulator_o))
        else $error("accumulator read wrong");
    // plain byte write lands in the visible bank
    chk_byte_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (byte_we_i && !acc_we_i && !flag_we_i && !pair_we_i && !exchange_i)
        |=> vis[$past(byte_wsel_i)] == $past(byte_wdata_i))
        else $error("byte write lost");
endmodule
`default_nettype wire

// ---- sim/crf_seq_model.sv ----
// sequencer and datapath model that drives the register file ports
`default_nettype none
module crf_seq_model
    import crf_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic [7:0] byte_rdata_i,
    input wire logic [15:0] pair_rdata_i,
    input wire logic [15:0] spc_rdata_i,
    output logic [2:0] rs_o,
    output logic [2:0] ws_o,
    output logic [15:0] wd_o,
    output logic [7:0] we_o,
    output logic [2:0] ien_o,
    output logic [7:0] per_o
);
    initial begin
        rs_o = 3'h0;
        ws_o = 3'h0;
        wd_o = 16'h0000;
        we_o = 8'h00;
        ien_o = IEN_NONE;
        per_o = 8'h42;
    end
    // one-hot strobe held one cycle; the #1 lets the write land before callers look
    task automatic op(input int k, input logic [2:0] s, input logic [15:0] d);
        @(posedge sys_clk_i);
        we_o <= 8'h01 << k;
        ws_o <= s;
        wd_o <= d;
        @(posedge sys_clk_i);
        we_o <= 8'h00;
        #1;
    endtask
    // one strobe held over two adjacent edges, as the sequencer may issue back to back
    task automatic op_twice(input int k);
        @(posedge sys_clk_i);
        we_o <= 8'h01 << k;
        @(posedge sys_clk_i);
        @(posedge sys_clk_i);
        we_o <= 8'h00;
        #1;
    endtask
    task automatic ien(input logic [2:0] c);
        @(posedge sys_clk_i);
        ien_o <= c;
        @(posedge sys_clk_i);
        ien_o <= IEN_NONE;
        #1;
    endtask
    // read data is registered, so it is taken one cycle after the select
    task automatic rd(input int k, input logic [2:0] s, output logic [15:0] q);
        @(posedge sys_clk_i);
        rs_o <= s;
        @(posedge sys_clk_i);
        #1;
        case (k)
            0: q = {8'h00, byte_rdata_i};
            1: q = pair_rdata_i;
            default: q = spc_rdata_i;
        endcase
    endtask
endmodule
`default_nettype wire

// ---- sim/tb_crf_top.sv ----
// self-checking bench for the cpu register file
`default_nettype none
module tb_crf_top;
    timeunit 1ns;
    timeprecision 1ps;
    import crf_pkg::*;
    logic sys_clk;
    logic rst_n;
    logic [2:0] rs, ws, ien;
    logic [15:0] wd, q, prd, srd, ix1, ix2, stk, pc, tptr;
    logic [7:0] we, per, brd, acc, flg, vb, rfa;
    logic bsel, efp, efs, mlo, mhi;
    int errors = 0;
    int total_checks = 0;
    crf_seq_model crf_seq_model_i (.sys_clk_i(sys_clk), .byte_rdata_i(brd),
        .pair_rdata_i(prd), .spc_rdata_i(srd), .rs_o(rs), .ws_o(ws), .wd_o(wd),
        .we_o(we), .ien_o(ien), .per_o(per));
    crf_top crf_top_i (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
        .byte_rsel_i(rs), .byte_rdata_o(brd), .byte_we_i(we[0]), .byte_wsel_i(ws),
        .byte_wdata_i(wd[7:0]), .pair_rsel_i(rs[1:0]), .pair_rdata_o(prd),
        .pair_we_i(we[1]), .pair_wsel_i(ws[1:0]), .pair_wdata_i(wd),
        .accumulator_o(acc), .flags_o(flg), .acc_we_i(we[3]), .acc_result_i(wd[7:0]),
        .flag_we_i(we[4]), .flag_result_i(wd[7:0]), .exchange_i(we[5]),
        .bank_sel_o(bsel), .spc_rsel_i(rs), .spc_rdata_o(srd), .spc_we_i(we[2]),
        .spc_wsel_i(ws), .spc_wdata_i(wd), .vector_base_o(vb), .index_first_o(ix1),
        .index_second_o(ix2), .stack_top_pointer_o(stk), .fetch_address_o(pc),
        .fetch_i(we[6]), .refresh_addr_o(rfa), .ien_cmd_i(ien), .mode_we_i(we[7]),
        .mode_wdata_i(wd[1:0]), .enable_flop_primary_o(efp),
        .enable_flop_saved_o(efs), .mode_flop_low_o(mlo), .mode_flop_high_o(mhi),
        .periph_vector_i(per), .table_pointer_o(tptr));
    always #5 sys_clk = ~sys_clk;
    function automatic logic [15:0] bv(input int i);
        return 16'(8'h11 * (i + 1));
    endfunction
    function automatic logic [15:0] sv(input int i);
        return 16'(16'h1357 + i * 16'h0202);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ien command table and the {primary,saved} state it should leave
    logic [2:0] cmds [5] = '{IEN_ON, IEN_NMI_ACCEPT, IEN_NMI_RETURN, IEN_OFF, IEN_NMI_RETURN};
    logic [1:0] efx [5] = '{2'h3, 2'h1, 2'h3, 2'h0, 2'h0};
    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            crf_seq_model_i.rd(0, i[2:0], q);
            chk(q, 16'h0000);
        end
        for (int i = 0; i < 6; i++) begin
            crf_seq_model_i.rd(2, i[2:0], q);
            chk(q, 16'h0000);
        end
        chk(16'({efp, efs, bsel}), 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 8; i++) crf_seq_model_i.op(0, i[2:0], bv(i));
        for (int i = 0; i < 8; i++) begin
            crf_seq_model_i.rd(0, i[2:0], q);
            chk(q, bv(i));
        end
        chk({flg, acc}, 16'h2211);
        $display("test bytes done");
        crf_seq_model_i.op(1, 3'h1, 16'habcd);
        crf_seq_model_i.rd(0, SEL_P1H, q);
        chk(q, 16'h00ab);
        crf_seq_model_i.rd(0, SEL_P1L, q);
        chk(q, 16'h00cd);
        crf_seq_model_i.rd(1, 3'h1, q);
        chk(q, 16'habcd);
        crf_seq_model_i.op(1, 3'h3, 16'hffff);
        crf_seq_model_i.rd(1, 3'h0, q);
        chk(q, 16'h3344);
        crf_seq_model_i.rd(1, 3'h2, q);
        chk(q, 16'h7788);
        $display("test pairs done");
        crf_seq_model_i.op(5, 3'h0, 16'h0000);
        chk(16'({bsel, acc}), 16'h0100);
        crf_seq_model_i.op(3, 3'h0, 16'h005a);
        crf_seq_model_i.op(4, 3'h0, 16'h00a5);
        chk({flg, acc}, 16'ha55a);
        crf_seq_model_i.op(5, 3'h0, 16'h0000);
        chk({flg, acc}, 16'h2211);
        crf_seq_model_i.rd(1, 3'h1, q);
        chk(q, 16'habcd);
        crf_seq_model_i.op(5, 3'h0, 16'h0000);
        chk(16'({bsel, acc}), 16'h015a);
        crf_seq_model_i.op_twice(5);
        chk(16'({bsel, acc}), 16'h015a);
        $display("test exchange done");
        for (int i = 0; i < 7; i++) crf_seq_model_i.op(2, i[2:0], sv(i));
        for (int i = 0; i < 7; i++) begin
            crf_seq_model_i.rd(2, i[2:0], q);
            chk(q, i < 2 ? {8'h00, 8'(sv(i))} : (i < 6 ? sv(i) : 16'h0000));
        end
        chk({8'h00, vb}, {8'h00, 8'(sv(0))});
        chk(ix1, sv(2));
        chk(ix2, sv(3));
        chk(stk, sv(4));
        chk(pc, sv(5));
        chk(tptr, {8'(sv(0)), 8'h42});
        $display("test special done");
        crf_seq_model_i.op(2, SPC_REFRESH, 16'h00fe);
        crf_seq_model_i.op(6, 3'h0, 16'h0000);
        chk({8'h00, rfa}, 16'h00ff);
        crf_seq_model_i.op(6, 3'h0, 16'h0000);
        chk({8'h00, rfa}, 16'h0080);
        $display("test refresh done");
        for (int i = 0; i < 5; i++) begin
            crf_seq_model_i.ien(cmds[i]);
            chk(16'({efp, efs}), 16'(efx[i]));
        end
        for (int i = 0; i < 3; i++) begin
            crf_seq_model_i.op(7, 3'h0, 16'(i));
            chk(16'({mhi, mlo}), 16'(i));
        end
        crf_seq_model_i.ien(IEN_ON);
        chk(16'({efp, efs}), 16'h0003);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(16'({efp, efs, mhi, mlo, bsel}), 16'h0000);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        crf_seq_model_i.rd(0, SEL_ACC, q);
        chk(q, 16'h0000);
        $display("test interrupt state done");
        summarize();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        summarize();
    end
endmodule
`default_nettype wire
